// file: logic/bus_arbiter.sv
// Arbiter for the external bus request, grant and busy lines
// Assumes: pins are active low, synchronised here; core sequences cycles
// Function
// R1: After reset request line is an input; device is slave, owns bus.
// R2: Asserted outside request is answered by grant a few T states later.
// R3: Bus is given up as early as synchronisation allows.
// R4: On release strobes tri-state and busy is released.
// R5: Internal operations continue while bus is released.
// R6: External access while released is stalled with wait states.
// R7: Bus regained only when request and busy inputs both deasserted.
// R8: Interrupts held off while an instruction waits for the bus.
// R9: No grant during a read-modify-write instruction.
// R10: Master bit drives request as output; request before external access.
// R11: Master mode waits for grant input with wait states.
// R12: Master access starts the edge after busy is sampled high.
// R13: Master keeps request asserted while the bus is needed.
// R14: Request hold bit keeps request asserted under software control.
// R15: Request held across data accesses, toggles across fetches unless hold.
// R16: With grant tied on, request follows accesses in T0 as chip select. Code never reads t0; request follows ext_req and the hold bit.
// R17: Master releases bus after current transfer when grant drops.
// R18: Owning device drives busy asserted; on release busy returns to input.
// R19: External cycle in progress finishes before grant and tri-state.
`timescale 1ns/1ps
module bus_arbiter (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     master_mode,
  input  wire logic                     request_hold_bit,
  input  wire bus_arb_pkg::core_req_t   core_req,
  input  wire bus_arb_pkg::bus_strobe_t strobe_in,
  input  wire logic                     bus_req_line_n_i,
  output logic                          bus_req_line_n_o,
  output logic                          bus_req_line_oe,
  input  wire logic                     bus_grant_line_n_i,
  output logic                          bus_grant_line_n_o,
  output logic                          bus_grant_line_oe,
  input  wire logic                     bus_busy_line_n_i,
  output logic                          bus_busy_line_n_o,
  output logic                          bus_busy_line_oe,
  output bus_arb_pkg::bus_strobe_t      strobe_out,
  output logic                          strobe_oe,
  output logic                          wait_state,
  output logic                          irq_block,
  output logic                          bus_owned
);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic req_n_s;
  logic grant_n_s;
  logic busy_n_s;

  sync2 #(.RESET_VAL(1'b1)) u_sync_req (
    .mclk  (mclk),
    .reset (reset),
    .din   (bus_req_line_n_i),
    .dout  (req_n_s)
  );
  sync2 #(.RESET_VAL(1'b1)) u_sync_grant (
    .mclk  (mclk),
    .reset (reset),
    .din   (bus_grant_line_n_i),
    .dout  (grant_n_s)
  );
  sync2 #(.RESET_VAL(1'b1)) u_sync_busy (
    .mclk  (mclk),
    .reset (reset),
    .din   (bus_busy_line_n_i),
    .dout  (busy_n_s)
  );

  // ****************************************************
  // Arbiter state
  // ****************************************************
  bus_arb_pkg::arb_state_t state_q;
  bus_arb_pkg::arb_state_t state_d;
  logic [3:0]              gcnt_q;
  logic                    busy_prev_q;
  logic                    busy_high_seen;

  // Busy sampled high (deasserted) in this cycle
  assign busy_high_seen = busy_n_s;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bus_arb_pkg::st_own: begin
        if (master_mode) begin
          state_d = bus_arb_pkg::st_idle_m;  // [R10]
        end else if (!req_n_s && !core_req.rmw && !core_req.cycle_busy
                     && gcnt_q == bus_arb_pkg::CNT_ONE) begin
          state_d = bus_arb_pkg::st_grant;  // [R2] [R3] [R9] [R19]
        end
      end
      bus_arb_pkg::st_grant: begin
        if (req_n_s && busy_n_s) begin
          state_d = bus_arb_pkg::st_own;  // [R7]
        end
      end
      bus_arb_pkg::st_idle_m: begin
        if (!master_mode) begin
          state_d = bus_arb_pkg::st_own;
        end else if (core_req.ext_req || request_hold_bit) begin
          state_d = bus_arb_pkg::st_req_m;  // [R10] [R14]
        end
      end
      bus_arb_pkg::st_req_m: begin
        if (!grant_n_s && busy_high_seen) begin
          state_d = bus_arb_pkg::st_have_m;  // [R11] [R12]
        end else if (!core_req.ext_req && !request_hold_bit) begin
          state_d = bus_arb_pkg::st_idle_m;
        end
      end
      bus_arb_pkg::st_have_m: begin
        if (!core_req.cycle_busy || core_req.cycle_done) begin
          if (grant_n_s) begin
            state_d = bus_arb_pkg::st_idle_m;  // [R17]
          end else if (!core_req.ext_req && !request_hold_bit) begin
            state_d = bus_arb_pkg::st_idle_m;  // [R13]
          end else if (core_req.ext_prog && core_req.cycle_done
                       && !request_hold_bit) begin
            state_d = bus_arb_pkg::st_idle_m;  // [R15] [R16]
          end
        end
      end
      default: state_d = bus_arb_pkg::st_own;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= bus_arb_pkg::st_own;  // [R1]
    end else begin
      state_q <= state_d;
    end
  end

  // Grant delay counter, counts T states of a held request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gcnt_q <= bus_arb_pkg::CNT_ZERO;
    end else if (state_q == bus_arb_pkg::st_own && !req_n_s) begin
      if (gcnt_q < 4'(bus_arb_pkg::GRANT_DELAY - 1)) begin
        gcnt_q <= gcnt_q + bus_arb_pkg::CNT_ONE;  // [R2]
      end
    end else begin
      gcnt_q <= bus_arb_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_prev_q <= 1'b1;
    end else begin
      busy_prev_q <= busy_n_s;
    end
  end

  // ****************************************************
  // Pin outputs
  // ****************************************************
  logic owns_d;
  assign owns_d = (state_d == bus_arb_pkg::st_own)
                || (state_d == bus_arb_pkg::st_have_m);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_req_line_oe    <= 1'b0;  // [R1]
      bus_req_line_n_o   <= 1'b1;
      bus_grant_line_oe  <= 1'b1;
      bus_grant_line_n_o <= 1'b1;
      bus_busy_line_oe   <= 1'b0;
      bus_busy_line_n_o  <= 1'b1;
      strobe_oe          <= 1'b0;
      bus_owned          <= 1'b0;
    end else begin
      bus_req_line_oe    <= master_mode;  // [R10]
      bus_req_line_n_o   <= !(state_d == bus_arb_pkg::st_req_m
                              || state_d == bus_arb_pkg::st_have_m); // [R13]
      bus_grant_line_oe  <= !master_mode;
      bus_grant_line_n_o <= !(state_d == bus_arb_pkg::st_grant);  // [R2]
      bus_busy_line_oe   <= owns_d;  // [R18]
      bus_busy_line_n_o  <= !owns_d;  // [R4] [R18]
      strobe_oe          <= owns_d;  // [R4]
      bus_owned          <= owns_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strobe_out <= '1;
    end else begin
      strobe_out <= strobe_in;
    end
  end

  // ****************************************************
  // Stall and interrupt hold-off
  // ****************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wait_state <= 1'b0;
      irq_block  <= 1'b0;
    end else begin
      // Internal work runs freely; only external accesses stall [R5]
      wait_state <= core_req.ext_req && !owns_d;  // [R6] [R11]
      irq_block  <= core_req.ext_req && !owns_d;  // [R8]
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  logic busy_n_o_ok;
  assign busy_n_o_ok = !bus_busy_line_oe;

  a_grant_needs_req: assert property (@(posedge mclk) // [R2]
    disable iff (reset)
    $rose(state_q == bus_arb_pkg::st_grant) |-> !$past(req_n_s))
    else $error("grant without request");
  a_grant_delay: assert property (@(posedge mclk) // [R2]
    disable iff (reset)
    $rose(state_q == bus_arb_pkg::st_grant) |-> !$past(req_n_s, 2))
    else $error("grant before request was held");
  a_grant_prompt: assert property (@(posedge mclk) // [R3]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_own && !master_mode && !req_n_s
     && !core_req.rmw && !core_req.cycle_busy
     && gcnt_q == bus_arb_pkg::CNT_ONE)
      |=> state_q == bus_arb_pkg::st_grant)
    else $error("grant delayed past count");
  a_no_grant_rmw: assert property (@(posedge mclk) // [R9]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_own && core_req.rmw)
      |=> state_q != bus_arb_pkg::st_grant)
    else $error("grant during read-modify-write");
  a_regain_rule: assert property (@(posedge mclk) // [R7]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_grant && (!req_n_s || !busy_n_s))
      |=> state_q == bus_arb_pkg::st_grant)
    else $error("bus regained too early");
  a_release_tris: assert property (@(posedge mclk) // [R4]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_grant) |-> !strobe_oe && busy_n_o_ok)
    else $error("strobes driven while released");
  a_wait_when_out: assert property (@(posedge mclk) // [R6]
    disable iff (reset)
    (core_req.ext_req && state_d == bus_arb_pkg::st_grant)
      |=> wait_state && irq_block)
    else $error("no stall while released");
  a_stall_not_owned: assert property (@(posedge mclk) // [R6]
    disable iff (reset)
    wait_state |-> !bus_owned)
    else $error("stall while owning bus");
  a_master_drives: assert property (@(posedge mclk) // [R10]
    disable iff (reset)
    master_mode |=> bus_req_line_oe)
    else $error("request not driven in master mode");
  a_slave_req_input: assert property (@(posedge mclk) // [R1]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_own) |-> !bus_req_line_oe)
    else $error("request driven in slave mode");
  a_start_busy_hi: assert property (@(posedge mclk) // [R12]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_req_m && !busy_n_s)
      |=> state_q != bus_arb_pkg::st_have_m)
    else $error("access started while busy");
  a_busy_seen_high: assert property (@(posedge mclk) // [R12]
    disable iff (reset)
    $rose(state_q == bus_arb_pkg::st_have_m) |-> busy_prev_q)
    else $error("access started before busy seen high");
  a_hold_keeps: assert property (@(posedge mclk) // [R14]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_have_m && request_hold_bit && !grant_n_s
     && master_mode) |=> !bus_req_line_n_o)
    else $error("request dropped with hold set");
  a_idle_in_cycle: assert property (@(posedge mclk) // [R19]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_own && core_req.cycle_busy)
      |=> state_q != bus_arb_pkg::st_grant)
    else $error("grant during cycle");
  a_master_release: assert property (@(posedge mclk) // [R17]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_have_m && grant_n_s && !core_req.cycle_busy)
      |=> state_q == bus_arb_pkg::st_idle_m)
    else $error("bus kept after grant dropped");
  a_busy_driven: assert property (@(posedge mclk) // [R18]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_have_m)
      |-> bus_busy_line_oe && !bus_busy_line_n_o)
    else $error("busy not driven while owning");
  a_req_while_need: assert property (@(posedge mclk) // [R13]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_have_m && core_req.ext_req && !grant_n_s
     && !core_req.ext_prog) |=> !bus_req_line_n_o)
    else $error("request dropped while needed");
  a_fetch_toggle: assert property (@(posedge mclk) // [R15]
    disable iff (reset)
    (state_q == bus_arb_pkg::st_have_m && core_req.ext_prog
     && core_req.cycle_done && !request_hold_bit) |=> bus_req_line_n_o)
    else $error("request not toggled after fetch");

  // ****************************************************
  // Cover points
  // ****************************************************
  c_grant: cover property (@(posedge mclk) disable iff (reset)
    $rose(state_q == bus_arb_pkg::st_grant));
  c_regain: cover property (@(posedge mclk) disable iff (reset)
    $fell(state_q == bus_arb_pkg::st_grant));
  c_master_have: cover property (@(posedge mclk) disable iff (reset)
    $rose(state_q == bus_arb_pkg::st_have_m));
  c_stall: cover property (@(posedge mclk) disable iff (reset)
    $rose(wait_state));
  c_fetch_toggle: cover property (@(posedge mclk) disable iff (reset)
    state_q == bus_arb_pkg::st_have_m && core_req.ext_prog
    && core_req.cycle_done);

endmodule : bus_arbiter

// file: logic/bus_arb_pkg.sv
// Package: types and constants for the external bus arbiter
// Assumes: used as bus_arb_pkg::name, never imported
package bus_arb_pkg;

  // Grant delay in T states after a sampled request
  localparam int unsigned GRANT_DELAY = 2;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;

  // One-hot arbiter states
  typedef enum logic [4:0] {
    st_own     = 5'h01,  // Slave mode, device owns bus
    st_grant   = 5'h02,  // Slave mode, bus granted away
    st_idle_m  = 5'h04,  // Master mode, not requesting
    st_req_m   = 5'h08,  // Master mode, waiting for grant
    st_have_m  = 5'h10   // Master mode, owns bus
  } arb_state_t;

  // Access request from the core
  typedef struct packed {
    logic ext_req;      // External access pending
    logic ext_prog;     // Access is a program fetch
    logic rmw;          // Inside read-modify-write
    logic cycle_busy;   // External cycle in progress
    logic cycle_done;   // Current external cycle ends
    logic t0;           // T0 phase of instruction cycle
  } core_req_t;

  // Bus pin strobes driven by the core
  typedef struct packed {
    logic periph_en_n;
    logic space_sel;
    logic rd_n;
    logic wr_n;
    logic rw;
  } bus_strobe_t;

endpackage : bus_arb_pkg

// file: logic/sync2.sv
// Two flip-flop synchroniser for pin inputs
// Assumes: single clock mclk, asynchronous active-high reset
`timescale 1ns/1ps
module sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_q <= RESET_VAL;
      dout   <= RESET_VAL;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : sync2

// file: bench/ext_bus_partner.sv
// Far-side bus party: requester in slave mode, arbiter in master mode
// Assumes: resolved active-low pin levels with pull-ups, drives low only
`timescale 1ns/1ps
module ext_bus_partner (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic arb,
  input  wire logic want,
  input  wire logic give,
  input  wire logic req_n,
  input  wire logic grant_n,
  output logic      req_oe,
  output logic      busy_oe,
  output logic      grant_oe,
  output logic      grant_n_o
);
  // ****************************************
  // Request, busy and grant drivers
  // ****************************************
  logic [1:0] tail_q;

  assign grant_oe = arb;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      req_oe    <= 1'b0;
      busy_oe   <= 1'b0;
      tail_q    <= 2'h0;
      grant_n_o <= 1'b1;
    end else begin
      req_oe    <= want;
      grant_n_o <= !(give && (!req_n || !grant_n_o));
      if (want && !grant_n) begin
        busy_oe <= 1'b1;
        tail_q  <= 2'h3;
      end else if (tail_q != 2'h0) begin
        tail_q  <= tail_q - 2'h1;
      end else begin
        busy_oe <= 1'b0;
      end
    end
  end
endmodule : ext_bus_partner

// file: bench/external_bus_request_arbitration_tb_top.sv
// Testbench for the external bus arbiter against the far-side party
// Assumes: 50 MHz mclk, pins resolved here with pull-ups
`timescale 1ns/1ps
module external_bus_request_arbitration_tb_top;
  // ****************************************
  // Signals, instances and pin resolution
  // ****************************************
  logic mclk, reset, master_mode, hold, want, give;
  bus_arb_pkg::core_req_t   core_req;
  bus_arb_pkg::bus_strobe_t strobe_in, strobe_out;
  logic req_o, req_oe, gnt_o, gnt_oe, busy_o, busy_oe;
  logic strobe_oe, wait_state, irq_block, bus_owned;
  logic p_req_oe, p_busy_oe, p_gnt_oe, p_gnt_o;
  logic req_n, grant_n, busy_n;
  int   fail_count, n_tests;

  assign req_n   = (req_oe ? req_o : 1'b1) & !p_req_oe;
  assign busy_n  = (busy_oe ? busy_o : 1'b1) & !p_busy_oe;
  assign grant_n = (gnt_oe ? gnt_o : 1'b1) & (p_gnt_oe ? p_gnt_o : 1'b1);

  bus_arbiter i_bus_arbiter (.mclk(mclk), .reset(reset),
    .master_mode(master_mode), .request_hold_bit(hold),
    .core_req(core_req), .strobe_in(strobe_in),
    .bus_req_line_n_i(req_n), .bus_req_line_n_o(req_o),
    .bus_req_line_oe(req_oe), .bus_grant_line_n_i(grant_n),
    .bus_grant_line_n_o(gnt_o), .bus_grant_line_oe(gnt_oe),
    .bus_busy_line_n_i(busy_n), .bus_busy_line_n_o(busy_o),
    .bus_busy_line_oe(busy_oe), .strobe_out(strobe_out),
    .strobe_oe(strobe_oe), .wait_state(wait_state),
    .irq_block(irq_block), .bus_owned(bus_owned));

  ext_bus_partner i_ext_bus_partner (.mclk(mclk), .reset(reset),
    .arb(master_mode), .want(want), .give(give), .req_n(req_n),
    .grant_n(grant_n), .req_oe(p_req_oe), .busy_oe(p_busy_oe),
    .grant_oe(p_gnt_oe), .grant_n_o(p_gnt_o));

  always #10 mclk = !mclk;

  // ****************************************
  // Compare, wait and closing tasks
  // ****************************************
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task automatic check_bit(input logic got, input logic exp, input string s);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %b", $time, s, got);
    end
  endtask : check_bit

  function automatic logic pick(input int s);
    case (s)
      0: return gnt_o;
      1: return bus_owned;
      2: return req_o;
      default: return busy_oe;
    endcase
  endfunction : pick

  task automatic wait_sig(input int s, input logic v);
    int i;
    for (i = 0; i < 30 && pick(s) !== v; i++) @(negedge mclk);
    check_bit(pick(s), v, "wait on pin or flag");
    if (pick(s) !== v) complete_run();
  endtask : wait_sig

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic slave_grant;
    core_req.ext_req = 1'b1;
    want = 1'b1;
    wait_sig(0, 1'b0);
    @(negedge mclk);
    check_bit(strobe_oe, 1'b0, "strobe enable");
    check_bit(busy_oe, 1'b0, "busy enable");
    check_bit(wait_state, 1'b1, "wait state");
    check_bit(irq_block, 1'b1, "irq block");
    want = 1'b0;
    repeat (2) @(negedge mclk);
    check_bit(gnt_o, 1'b0, "grant while busy");
    wait_sig(0, 1'b1);
    wait_sig(1, 1'b1);
    check_bit(strobe_oe, 1'b1, "strobe enable back");
    core_req.ext_req = 1'b0;
  endtask : slave_grant

  task automatic held_off(input int k);
    if (k == 0) core_req.rmw = 1'b1;
    else core_req.cycle_busy = 1'b1;
    want = 1'b1;
    repeat (12) @(negedge mclk);
    check_bit(gnt_o, 1'b1, "grant withheld");
    core_req.rmw = 1'b0;
    core_req.cycle_busy = 1'b0;
    wait_sig(0, 1'b0);
    want = 1'b0;
    wait_sig(0, 1'b1);
  endtask : held_off

  task automatic master_cycle;
    master_mode = 1'b1;
    repeat (4) @(negedge mclk);
    check_bit(req_oe, 1'b1, "request enable");
    core_req.ext_req = 1'b1;
    wait_sig(2, 1'b0);
    repeat (6) @(negedge mclk);
    check_bit(wait_state, 1'b1, "wait for grant");
    give = 1'b1;
    wait_sig(1, 1'b1);
    check_bit(busy_o, 1'b0, "busy driven low");
    check_bit(req_o, 1'b0, "request held");
    check_bit(gnt_oe, 1'b0, "grant is input");
    hold = 1'b1;
    core_req.ext_req = 1'b0;
    repeat (3) @(negedge mclk);
    check_bit(req_o, 1'b0, "request kept by hold");
    check_bit(bus_owned, 1'b1, "bus kept by hold");
    core_req.ext_req = 1'b1;
    hold = 1'b0;
    core_req.ext_prog = 1'b1;
    core_req.cycle_done = 1'b1;
    @(negedge mclk);
    check_bit(req_o, 1'b1, "request toggles on fetch");
    core_req.ext_prog = 1'b0;
    core_req.cycle_done = 1'b0;
    repeat (8) @(negedge mclk);
    check_bit(bus_owned, 1'b1, "bus regained after fetch");
    give = 1'b0;
    core_req.cycle_done = 1'b1;
    @(negedge mclk);
    core_req.cycle_done = 1'b0;
    wait_sig(1, 1'b0);
    wait_sig(3, 1'b0);
    core_req.ext_req = 1'b0;
    wait_sig(2, 1'b1);
    hold = 1'b1;
    wait_sig(2, 1'b0);
    hold = 1'b0;
    wait_sig(2, 1'b1);
  endtask : master_cycle

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    {master_mode, hold, want, give} = 4'h0;
    core_req = '0;
    strobe_in = 5'h15;
    fail_count = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    check_bit(req_oe, 1'b0, "request is input");
    check_bit(gnt_oe, 1'b1, "grant is output");
    check_bit(strobe_out === 5'h15, 1'b1, "strobe pass");
    slave_grant();
    held_off(0);
    held_off(1);
    master_cycle();
    complete_run();
  end
endmodule : external_bus_request_arbitration_tb_top
